//--- core/i2csr_pkg.sv
// Constants and types for the two-wire register-access slave port
package i2csr_pkg;

  // Fixed upper six bits of the slave address
  localparam logic [5:0] ADDR_HI    = 6'h2E;
  localparam int         DATA_W     = 8;
  localparam int         REG_AW     = 7;
  localparam int         FIFO_DEPTH = 16;
  // Bit count at which a received byte is complete
  localparam logic [3:0] BIT_LAST   = 4'h8;
  // Bit count of the last transmitted bit
  localparam logic [3:0] BIT_TX_END = 4'h7;
  localparam logic [6:0] PTR_STEP   = 7'h01;

  typedef enum logic [2:0] {
    PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_MACK, PH_IGNORE
  } i2csr_state_t;

  // Meaning of the byte currently in flight
  typedef enum logic [1:0] {K_ADDR, K_SUB, K_DATA} i2csr_kind_t;

  // One register write handed to the register file
  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } i2csr_wr_t;

  // Whole state of the protocol engine
  typedef struct packed {
    logic [1:0]        scl_s;
    logic [1:0]        sda_s;
    logic [1:0]        cs_s;
    logic [1:0]        lsb_s;
    logic              scl_d;
    logic              sda_d;
    i2csr_state_t      st;
    i2csr_kind_t       kind;
    logic [3:0]        bitcnt;
    logic [DATA_W-1:0] shreg;
    logic              rw;
    logic              inc;
    logic              mack;
    logic [REG_AW-1:0] ptr;
    logic              sda_low;
    logic              scl_hold;
    logic              busy;
    logic              rd_stb;
  } i2csr_core_t;

  localparam i2csr_core_t CORE_RST = '0;

endpackage : i2csr_pkg

//--- core/i2csr_slave.sv
// Two-wire slave port with write buffer and register pointer
`timescale 1ns/100ps

// Write buffer between the serial engine and the register file
module i2csr_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  import i2csr_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } i2csr_fptr_t;

  i2csr_fptr_t      q_reg;
  i2csr_fptr_t      q_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_o  = (q_reg.cnt != FULL);
  assign out_valid_o = (q_reg.cnt != '0);
  assign out_data_o  = mem[q_reg.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    q_next = q_reg;
    if (push) begin
      q_next.wp = q_reg.wp + 1'b1;
    end
    if (pop) begin
      q_next.rp = q_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      q_next.cnt = q_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      q_next.cnt = q_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Storage needs no reset; only counted words are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[q_reg.wp] <= in_data_i;
    end
  end
endmodule : i2csr_fifo

// Contract
// (RQ1) Interface-select high enables this port; low keeps it idle.
// (RQ2) Address is fixed six bits plus the strapped low bit.
// (RQ3) Works at standard and fast-mode bus clock rates.
// (RQ4) Falling data while clock high is a start; bus then busy.
// (RQ5) Rising data while clock high is a stop ending the transfer.
// (RQ6) First seven bits after start are compared; eighth is direction.
// (RQ7) Receiver pulls data low through the acknowledge clock high phase.
// (RQ8) Device acknowledges address, sub-address and write data bytes.
// (RQ9) Byte after address: low seven bits register, top bit increment.
// (RQ10) With increment set, pointer advances after every data byte.
// (RQ11) Reads: write address, sub-address, repeated start, read address.
// (RQ12) Address plus direction gives four byte values.
// (RQ13) Writes send data bytes after sub-address, then a stop.
// (RQ14) Bursts have no length limit.
// (RQ15) Bytes are eight bits, most significant bit first.
// (RQ16) Master acknowledges read bytes except the last one.
// (RQ17) A receiver not ready may hold the clock low to stall.
// (RQ18) Slave that refuses its address leaves data high in ack slot.
// (RQ19) On address mismatch, data stays released until next start.
module i2csr_slave (
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     cs_i,
  input  wire logic                     addr_lsb_strap_i,
  input  wire logic                     scl_i,
  output logic                          scl_o,
  output logic                          scl_oe_o,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  output logic                          bus_busy_o,
  output logic [i2csr_pkg::REG_AW-1:0]  rd_addr_o,
  input  wire logic [i2csr_pkg::DATA_W-1:0] rd_data_i,
  output logic                          rd_strobe_o,
  output logic                          wr_valid_o,
  input  wire logic                     wr_ready_i,
  output i2csr_pkg::i2csr_wr_t          wr_o
);
  import i2csr_pkg::*;

  i2csr_core_t q_reg;
  i2csr_core_t q_next;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        fifo_ready;
  logic [6:0]  slave_addr;
  i2csr_wr_t   fifo_in;
  // Load a read byte: first bit goes out at once, pointer steps after when increment is set
  function automatic i2csr_core_t load_byte(input i2csr_core_t c,
                                            input logic [7:0] d);
    i2csr_core_t r;
    r         = c;
    r.st      = PH_TX;
    r.kind    = K_DATA;
    r.bitcnt  = '0;
    r.shreg   = d;
    r.sda_low = ~d[7];                              // RQ15
    r.rd_stb  = 1'b1;
    if (c.inc) begin
      r.ptr = c.ptr + PTR_STEP;                     // RQ10
    end
    return r;
  endfunction : load_byte

  // Edges seen on the second synchroniser stage only; 100 MHz sampling
  // leaves hundreds of samples per fast-mode bit
  assign scl_rise   = q_reg.scl_s[1] & ~q_reg.scl_d;                // RQ3
  assign scl_fall   = ~q_reg.scl_s[1] & q_reg.scl_d;
  assign start_cond = q_reg.sda_d & ~q_reg.sda_s[1]
                    & q_reg.scl_s[1] & q_reg.scl_d;                 // RQ4
  assign stop_cond  = ~q_reg.sda_d & q_reg.sda_s[1]
                    & q_reg.scl_s[1] & q_reg.scl_d;                 // RQ5
  assign slave_addr = {ADDR_HI, q_reg.lsb_s[1]};                    // RQ2
  assign fifo_in    = '{addr: q_reg.ptr, data: q_reg.shreg};

  // Protocol engine next state
  always_comb begin
    q_next        = q_reg;
    q_next.scl_s  = {q_reg.scl_s[0], scl_i};
    q_next.sda_s  = {q_reg.sda_s[0], sda_i};
    q_next.cs_s   = {q_reg.cs_s[0], cs_i};
    q_next.lsb_s  = {q_reg.lsb_s[0], addr_lsb_strap_i};
    q_next.scl_d  = q_reg.scl_s[1];
    q_next.sda_d  = q_reg.sda_s[1];
    q_next.rd_stb = 1'b0;
    if (!q_reg.cs_s[1]) begin
      // Pads belong to the other interface; stay off the lines
      q_next.st       = PH_IDLE;                    // RQ1
      q_next.sda_low  = 1'b0;
      q_next.scl_hold = 1'b0;
      q_next.busy     = 1'b0;
    end else if (start_cond) begin
      // Also covers a repeated start from any state
      q_next.st       = PH_RX;                      // RQ4
      q_next.kind     = K_ADDR;
      q_next.bitcnt   = '0;
      q_next.sda_low  = 1'b0;
      q_next.scl_hold = 1'b0;
      q_next.busy     = 1'b1;
    end else if (stop_cond) begin
      q_next.st       = PH_IDLE;                    // RQ5
      q_next.sda_low  = 1'b0;
      q_next.scl_hold = 1'b0;
      q_next.busy     = 1'b0;
    end else begin
      case (q_reg.st)
        PH_RX: begin
          if (q_reg.scl_hold) begin
            // Held low until the buffer takes the byte; ack is already out
            if (fifo_ready) begin
              q_next.scl_hold = 1'b0;               // RQ17
              q_next.st       = PH_ACK;
              if (q_reg.inc) begin
                q_next.ptr = q_reg.ptr + PTR_STEP;  // RQ10
              end
            end
          end else if (scl_rise) begin
            q_next.shreg  = {q_reg.shreg[6:0], q_reg.sda_s[1]}; // RQ15
            q_next.bitcnt = q_reg.bitcnt + 1'b1;
          end else if (scl_fall && q_reg.bitcnt == BIT_LAST) begin
            q_next.bitcnt = '0;
            case (q_reg.kind)
              K_ADDR: begin
                if (q_reg.shreg[7:1] == slave_addr) begin       // RQ6
                  q_next.rw      = q_reg.shreg[0];              // RQ12
                  q_next.st      = PH_ACK;
                  q_next.sda_low = 1'b1;                        // RQ8
                end else begin
                  q_next.st = PH_IGNORE;                        // RQ18 RQ19
                end
              end
              K_SUB: begin
                q_next.ptr     = q_reg.shreg[6:0];              // RQ9
                q_next.inc     = q_reg.shreg[7];
                q_next.st      = PH_ACK;
                q_next.sda_low = 1'b1;                          // RQ8
              end
              default: begin
                q_next.scl_hold = 1'b1;                         // RQ17
                q_next.sda_low  = 1'b1;                         // RQ8
              end
            endcase
          end
        end
        PH_ACK: begin
          // Low held from one falling clock edge to the next
          if (scl_fall) begin                       // RQ7
            q_next.sda_low = 1'b0;
            q_next.bitcnt  = '0;
            if (q_reg.kind == K_ADDR && q_reg.rw) begin
              q_next = load_byte(q_next, rd_data_i);
            end else begin
              q_next.st   = PH_RX;
              q_next.kind = (q_reg.kind == K_ADDR) ? K_SUB : K_DATA;
            end
          end
        end
        PH_TX: begin
          if (scl_fall) begin
            q_next.bitcnt = q_reg.bitcnt + 1'b1;
            if (q_reg.bitcnt == BIT_TX_END) begin
              q_next.sda_low = 1'b0;                // RQ7
              q_next.st      = PH_MACK;
            end else begin
              q_next.shreg   = {q_reg.shreg[6:0], 1'b0};
              q_next.sda_low = ~q_reg.shreg[6];     // RQ15
            end
          end
        end
        PH_MACK: begin
          if (scl_rise) begin
            q_next.mack = ~q_reg.sda_s[1];
          end else if (scl_fall) begin
            if (q_reg.mack) begin
              q_next = load_byte(q_next, rd_data_i); // RQ14
            end else begin
              q_next.st = PH_IGNORE;                // RQ16
            end
          end
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_reg <= CORE_RST;
    end else begin
      q_reg <= q_next;
    end
  end
  // Write buffer; a full buffer stretches the clock on the bus
  i2csr_fifo #(
    .WIDTH ($bits(i2csr_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (q_reg.scl_hold),
    .in_ready_o  (fifo_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (wr_o)
  );
  // Open-drain pins: only ever pull low
  assign sda_o       = 1'b0;
  assign sda_oe_o    = q_reg.sda_low;
  assign scl_o       = 1'b0;
  assign scl_oe_o    = q_reg.scl_hold;              // RQ17
  assign bus_busy_o  = q_reg.busy;
  assign rd_addr_o   = q_reg.ptr;
  assign rd_strobe_o = q_reg.rd_stb;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_byte_in;
    q_reg.st == PH_RX && !q_reg.scl_hold && scl_fall
      && q_reg.bitcnt == BIT_LAST;
  endsequence
  a_ack_held_low: assert property (             // RQ7
    q_reg.st == PH_ACK && scl_rise |-> sda_oe_o)
    else $error("ack not driven low at clock high");
  a_mismatch_quiet: assert property (           // RQ19
    q_reg.st == PH_IGNORE |-> !sda_oe_o)
    else $error("data driven after address mismatch");
  a_start_restart: assert property (            // RQ4
    q_reg.cs_s[1] && start_cond |=> q_reg.st == PH_RX
      && q_reg.kind == K_ADDR && q_reg.bitcnt == '0 && bus_busy_o)
    else $error("start did not restart address phase");
  a_stop_idle: assert property (                // RQ5
    q_reg.cs_s[1] && !start_cond && stop_cond
      |=> q_reg.st == PH_IDLE && !bus_busy_o && !sda_oe_o)
    else $error("stop did not free the bus");
  a_select_off: assert property (               // RQ1
    !q_reg.cs_s[1] |=> !sda_oe_o && !scl_oe_o)
    else $error("lines driven while deselected");
  a_addr_match: assert property (               // RQ6
    s_byte_in ##0 (q_reg.cs_s[1] && !start_cond && !stop_cond
      && q_reg.kind == K_ADDR)
      |=> (q_reg.st == PH_ACK) == ($past(q_reg.shreg[7:1]) == slave_addr))
    else $error("address compare wrong");
  a_sub_load: assert property (                 // RQ9
    s_byte_in ##0 (q_reg.cs_s[1] && !start_cond && !stop_cond
      && q_reg.kind == K_SUB)
      |=> q_reg.ptr == $past(q_reg.shreg[6:0])
        && q_reg.inc == $past(q_reg.shreg[7]) && sda_oe_o)
    else $error("sub-address not taken");
  a_burst_step: assert property (               // RQ10
    q_reg.scl_hold && fifo_ready && q_reg.cs_s[1] && !start_cond
      && !stop_cond |=> q_reg.ptr == $past(q_reg.ptr)
        + ($past(q_reg.inc) ? PTR_STEP : 7'h00))
    else $error("pointer step wrong after write");
  a_stretch_hold: assert property (             // RQ17
    q_reg.scl_hold && !fifo_ready && q_reg.cs_s[1] && !start_cond
      && !stop_cond |-> scl_oe_o ##1 q_reg.scl_hold)
    else $error("clock released while buffer full");
  a_ack_before_release: assert property (       // RQ7
    q_reg.scl_hold |-> sda_oe_o)
    else $error("ack not set up before clock release");
  a_tx_msb: assert property (                   // RQ15
    rd_strobe_o |-> sda_oe_o == ~q_reg.shreg[7])
    else $error("first read bit is not the msb");
endmodule : i2csr_slave

//--- dv/i2csr_master.sv
// Two-wire bus master model that drives the slave through tasks
`timescale 1ns/100ps
module i2csr_master (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Quarter of the 125 ns link clock; the clock stands high between frames
  localparam realtime Q = 31.25;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One clock with data b; r samples the line in mid high phase
  task automatic clk_bit(input logic b, output logic r);
    int n;
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    n = 0;
    // Honour a stretched clock, bounded so a stuck line cannot hang us
    while (scl_i !== 1'b1 && n < 4000) begin
      #1 n++;
    end
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask : clk_bit

  // Data falls while the clock is high; also serves as repeated start
  task automatic start;
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask : start

  // Data rises while the clock is high, leaving the bus idle
  task automatic stop;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask : stop

  // Byte out, then the line released for the acknowledge slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask : send

  // Byte in; every byte acknowledged except the last
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, r);
  endtask : recv
endmodule : i2csr_master

//--- dv/i2csr_slave_test.sv
// Self-checking bench for the two-wire register-access slave
`timescale 1ns/100ps
module i2csr_slave_test;
  import i2csr_pkg::*;
  typedef struct packed {
    logic       strap;
    logic [7:0] adr;
    logic [7:0] sub;
    logic [7:0] dat;
    logic       ack;
  } i2csr_row_t;
  // Strap, address byte, sub-address, first data, expected acknowledge
  localparam i2csr_row_t ROWS [5] = '{
    '{1'b0, 8'hB8, 8'h08, 8'hA5, 1'b1},
    '{1'b1, 8'hBA, 8'hFF, 8'h5A, 1'b1},
    '{1'b0, 8'hBA, 8'h10, 8'h11, 1'b0},
    '{1'b1, 8'hB8, 8'h10, 8'h22, 1'b0},
    '{1'b0, 8'h38, 8'h10, 8'h33, 1'b0}};
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cs_i     = 1'b1;
  logic        strap    = 1'b0;
  logic        wr_ready = 1'b1;
  logic        scl_m;
  logic        sda_m;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl_pd;
  logic        sda_pd;
  logic        busy;
  logic        rd_stb;
  logic        wr_valid;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  i2csr_wr_t   wr;
  logic [14:0] got[$];
  int          strobes;
  int          bad_count   = 0;
  int          check_count = 0;
  // Open-drain lines with pull-ups: anyone may pull low
  wire scl_line = scl_m & (scl_oe ? scl_pd : 1'b1);
  wire sda_line = sda_m & (sda_oe ? sda_pd : 1'b1);
  // Register file contents follow the pointer at all times
  assign rd_data = {1'b1, rd_addr} ^ 8'h3C;

  always #5 clk_i = ~clk_i;

  i2csr_master bus (.scl_i(scl_line), .sda_i(sda_line),
                    .scl_o(scl_m), .sda_o(sda_m));

  i2csr_slave dut (.clk_i(clk_i), .resetn_i(resetn_i), .cs_i(cs_i),
    .addr_lsb_strap_i(strap), .scl_i(scl_line), .scl_o(scl_pd),
    .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(sda_pd),
    .sda_oe_o(sda_oe),
    .bus_busy_o(busy), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .rd_strobe_o(rd_stb), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .wr_o(wr));

  // Collect words taken from the write buffer and read loads
  always @(posedge clk_i) begin
    if (wr_valid && wr_ready) got.push_back(wr);
    if (rd_stb) strobes++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // Whole run needs about 0.08 ms of link traffic
  initial begin
    #1_000_000;
    bad_count++;
    conclude();
  end

  initial begin
    i2csr_row_t r;
    logic       ack;
    logic [7:0] d;
    logic [7:0] sub;
    logic [6:0] a;
    int         n;
    repeat (10) @(negedge clk_i);
    check({sda_oe, scl_oe, busy, wr_valid, rd_stb, rd_addr}, 0);
    resetn_i = 1'b1;
    // Writes of two bytes, matching and foreign addresses
    foreach (ROWS[k]) begin
      r = ROWS[k];
      @(negedge clk_i) strap = r.strap;
      repeat (4) @(negedge clk_i);
      got.delete();
      bus.start();
      bus.send(r.adr, ack);
      check(ack, r.ack);
      check(busy, 1);
      bus.send(r.sub, ack);
      check(ack, r.ack);
      bus.send(r.dat, ack);
      check(ack, r.ack);
      bus.send(~r.dat, ack);
      check(ack, r.ack);
      bus.stop();
      repeat (8) @(negedge clk_i);
      check(busy, 0);
      check(16'(got.size()), r.ack ? 16'h0002 : 16'h0000);
      a = r.sub[7] ? r.sub[6:0] + 7'h01 : r.sub[6:0];
      if (r.ack) begin
        check(got[0], {r.sub[6:0], r.dat});
        check(got[1], {a, ~r.dat});
      end
    end
    $display("write rows done");
    // Reads with repeated start, both straps, with and without increment
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i) strap = i[0];
      sub = i[1] ? 8'hFE : 8'h05;
      strobes = 0;
      repeat (4) @(negedge clk_i);
      bus.start();
      bus.send({ADDR_HI, strap, 1'b0}, ack);
      bus.send(sub, ack);
      bus.start();
      bus.send({ADDR_HI, strap, 1'b1}, ack);
      check(ack, 1);
      for (int j = 0; j < 3; j++) begin
        bus.recv(j == 2, d);
        a = sub[7] ? sub[6:0] + j[6:0] : sub[6:0];
        check(d, {1'b1, a} ^ 8'h3C);
      end
      bus.stop();
      check(16'(strobes), 3);
    end
    $display("reads done");
    // Register file stalls: buffer fills, clock is held low, then drains
    @(negedge clk_i) wr_ready = 1'b0;
    got.delete();
    fork
      begin
        bus.start();
        bus.send({ADDR_HI, strap, 1'b0}, ack);
        bus.send(8'hF8, ack);
        for (int j = 0; j < 18; j++) begin
          bus.send(8'h40 + j[7:0], ack);
          check(ack, 1);
        end
        bus.stop();
      end
      begin
        n = 0;
        while (n < 20) @(negedge clk_i) n = scl_oe === 1'b1 ? n + 1 : 0;
        check(scl_line, 0);
        check(16'(got.size()), 0);
        wr_ready = 1'b1;
      end
    join
    repeat (20) @(negedge clk_i);
    check(16'(got.size()), 18);
    for (int j = 0; j < 18; j++) begin
      check(got[j], {7'h78 + j[6:0], 8'h40 + j[7:0]});
    end
    check(wr_valid, 0);
    $display("buffer stall done");
    // Deselected port stays silent
    @(negedge clk_i) cs_i = 1'b0;
    repeat (4) @(negedge clk_i);
    bus.start();
    bus.send({ADDR_HI, strap, 1'b0}, ack);
    check(ack, 0);
    check(busy, 0);
    bus.stop();
    @(negedge clk_i) cs_i = 1'b1;
    // Reset lands while the address acknowledge is being driven
    repeat (4) @(negedge clk_i);
    bus.start();
    bus.send({ADDR_HI, strap, 1'b0}, ack);
    @(negedge clk_i) resetn_i = 1'b0;
    @(negedge clk_i);
    check({sda_oe, scl_oe, busy, wr_valid, rd_stb, rd_addr}, 0);
    resetn_i = 1'b1;
    // Let the synchronisers settle before the bus moves again
    repeat (4) @(negedge clk_i);
    bus.stop();
    // Port works again after the reset: one byte written
    repeat (4) @(negedge clk_i);
    got.delete();
    bus.start();
    bus.send({ADDR_HI, strap, 1'b0}, ack);
    check(ack, 1);
    bus.send(8'h33, ack);
    bus.send(8'hC3, ack);
    check(ack, 1);
    bus.stop();
    repeat (8) @(negedge clk_i);
    check(busy, 0);
    check(16'(got.size()), 1);
    check(got[0], {7'h33, 8'hC3});
    $display("select and reset done");
    conclude();
  end
endmodule : i2csr_slave_test
